// File: logic/cdr_pkg.sv
// package of offsets, fields, reset values and carriers for the clock-detect register bank
package cdr_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] CDR_OFF_CLKDET = 8'h39;
   localparam logic [7:0] CDR_OFF_PGM    = 8'h40;
   localparam logic [7:0] CDR_OFF_DSPCTL = 8'h46;

   // ==========================================================
   // reset values
   localparam logic [7:0] CDR_RST_CLKDET = 8'h00;
   localparam logic [7:0] CDR_RST_PGM    = 8'h01;
   localparam logic [7:0] CDR_RST_DSPCTL = 8'h01;

   // ==========================================================
   // field positions
   localparam int CDR_FLAG_RATE_ERR   = 0;
   localparam int CDR_FLAG_BCLK_OK    = 1;
   localparam int CDR_FLAG_BCLK_MISS  = 2;
   localparam int CDR_FLAG_PLL_LOCK   = 3;
   localparam int CDR_FLAG_PLL_OVER   = 4;
   localparam int CDR_FLAG_BCLK_RANGE = 5;
   localparam int CDR_FLAG_MSB        = 5;
   localparam int CDR_PGM_LEFT_FLOAT  = 3;
   localparam int CDR_PGM_RIGHT_FLOAT = 2;
   localparam int CDR_PGM_SEL_MSB     = 1;
   localparam int CDR_DSPCTL_COEFF    = 0;
   localparam int CDR_DSPCTL_RW_LSB   = 3;

   // ==========================================================
   // bit-clock ratio window and program codes
   localparam logic [9:0] CDR_RATIO_MIN = 10'h020;
   localparam logic [9:0] CDR_RATIO_MAX = 10'h200;
   localparam logic [1:0] CDR_PGM_RAM   = 2'h0;
   localparam logic [1:0] CDR_PGM_ROM1  = 2'h1;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cdr_req_t;

   typedef struct packed {
      logic       auto_mode;
      logic       rate_valid;
      logic       rate_mismatch;
      logic       error_ignore;
      logic [9:0] bclk_ratio;
      logic       ratio_stable;
      logic       bclk_missing;
      logic       pll_enable;
      logic       pll_overrate;
      logic       bclk_out_of_range;
   } cdr_det_t;
endpackage

// File: logic/cdr_sync.sv
// two-flop level synchroniser, one bit per lane
`timescale 1ns/10ps
`default_nettype none
module cdr_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// File: logic/cdr_regs.sv
// clock-detect status, forced-float channel control and dsp program registers
// Operation
// - auto rate mode: status bit 0 flags an invalid incoming sample rate.
// - fixed rate mode: status bit 0 flags configured versus detected rate mismatch.
// - rate error flag still raised when error-ignore setting is active.
// - status bit 1 set when bit-clock ratio stable and within 32 to 512.
// - status bit 2 reports a missing bit clock.
// - status bit 3 shows pll lock; disabled pll reads unlocked.
// - status bit 4 reports pll running over rate.
// - status bit 5 reports bit clock over or under its range.
// - program register bit 3 high floats the left output channel.
// - program register bit 2 high floats the right output channel.
// - clearing a force bit returns the channel to channel control register.
// - a forced channel is released only by writing its force bit low.
// - forced float has no effect in parallel bridged mono mode.
// - two-bit program select: 00 ram, 01..11 rom one to three; resets 01.
// - coefficient select 1 uses built-in rom, 0 host-loaded; resets 1.
`timescale 1ns/10ps
`default_nettype none
module cdr_regs (
   input  wire logic            clock,
   input  wire logic            rst_n,
   input  wire logic            link_clock,
   input  wire logic            bus_req,
   input  wire cdr_pkg::cdr_req_t bus_cmd,
   output logic                 bus_busy,
   output logic                 bus_ack,
   output logic [7:0]           bus_rdata,
   input  wire cdr_pkg::cdr_det_t det,
   input  wire logic            pll_locked,
   input  wire logic            parallel_bridged_mono,
   input  wire logic            left_ctrl_float,
   input  wire logic            right_ctrl_float,
   output logic                 left_output_float,
   output logic                 right_output_float,
   output logic                 left_force_float,
   output logic                 right_force_float,
   output logic [1:0]           program_select,
   output logic                 builtin_coefficient_select
);
   import cdr_pkg::*;

   // ==========================================================
   // link side: hold the command and toggle a request across
   cdr_req_t   hold_q;
   logic       busy_q;
   logic       req_tog_q;
   logic       ack_seen_q;
   logic       ack_s;
   logic       bus_ack_q;
   logic [7:0] bus_rdata_q;
   logic [7:0] core_rdata_q;
   wire        link_take = bus_req & ~busy_q;
   wire        link_done = ack_s ^ ack_seen_q;

   // a new request is refused while one is in flight so the held command stays stable
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_q    <= '0;
         req_tog_q <= 1'b0;
      end else if (link_take) begin
         hold_q    <= bus_cmd;
         req_tog_q <= ~req_tog_q;
      end
   end

   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_q      <= 1'b0;
         ack_seen_q  <= 1'b0;
         bus_ack_q   <= 1'b0;
         bus_rdata_q <= 8'h00;
      end else begin
         busy_q     <= link_take | (busy_q & ~link_done);
         ack_seen_q <= ack_s;
         bus_ack_q  <= link_done;
         if (link_done) begin
            bus_rdata_q <= core_rdata_q;
         end
      end
   end

   assign bus_busy  = busy_q;
   assign bus_ack   = bus_ack_q;
   assign bus_rdata = bus_rdata_q;

   // ==========================================================
   // crossings
   logic req_s;
   logic ack_tog_q;
   logic lock_s;

   cdr_sync #(.W(1)) u_req_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     (req_tog_q),
      .q     (req_s)
   );

   cdr_sync #(.W(1)) u_ack_sync (
      .clock (link_clock),
      .rst_n (rst_n),
      .d     (ack_tog_q),
      .q     (ack_s)
   );

   // pll lock comes from analog logic, so it is synchronised before use
   cdr_sync #(.W(1)) u_lock_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     (pll_locked),
      .q     (lock_s)
   );

   // ==========================================================
   // core side decode; held command is stable while the toggle is pending
   logic req_seen_q;
   wire  core_go   = req_s ^ req_seen_q;
   wire  core_wr   = core_go & hold_q.write;
   wire  hit_det   = hold_q.addr == CDR_OFF_CLKDET;
   wire  hit_pgm   = hold_q.addr == CDR_OFF_PGM;
   wire  hit_dsp   = hold_q.addr == CDR_OFF_DSPCTL;
   wire  wr_det    = core_wr & hit_det;
   wire  wr_pgm    = core_wr & hit_pgm;
   wire  wr_dsp    = core_wr & hit_dsp;

   // ==========================================================
   // detector flags
   logic [CDR_FLAG_MSB:0] flag_q;
   logic [CDR_FLAG_MSB:0] flag_d;
   logic [7:6]            det_rsvd_q;
   wire  ratio_in_window = (det.bclk_ratio >= CDR_RATIO_MIN) &&
                           (det.bclk_ratio <= CDR_RATIO_MAX);
   // error_ignore deliberately plays no part in the rate flag
   wire  rate_err = det.auto_mode ? ~det.rate_valid : det.rate_mismatch;

   assign flag_d[CDR_FLAG_RATE_ERR]   = rate_err;
   assign flag_d[CDR_FLAG_BCLK_OK]    = det.ratio_stable & ratio_in_window;
   assign flag_d[CDR_FLAG_BCLK_MISS]  = det.bclk_missing;
   assign flag_d[CDR_FLAG_PLL_LOCK]   = lock_s & det.pll_enable;
   assign flag_d[CDR_FLAG_PLL_OVER]   = det.pll_overrate;
   assign flag_d[CDR_FLAG_BCLK_RANGE] = det.bclk_out_of_range;

   // flags are refreshed every cycle; a host write never reaches them
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= CDR_RST_CLKDET[CDR_FLAG_MSB:0];
      end else begin
         flag_q <= flag_d;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         det_rsvd_q <= CDR_RST_CLKDET[7:6];
      end else if (wr_det) begin
         det_rsvd_q <= hold_q.wdata[7:6];
      end
   end

   // ==========================================================
   // program mode and dsp control
   logic [7:0] pgm_q;
   logic [7:3] dsp_rw_q;
   logic       coeff_q;

   // only a host write changes the force bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pgm_q <= CDR_RST_PGM;
      end else if (wr_pgm) begin
         pgm_q <= hold_q.wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dsp_rw_q <= CDR_RST_DSPCTL[7:3];
         coeff_q  <= CDR_RST_DSPCTL[CDR_DSPCTL_COEFF];
      end else if (wr_dsp) begin
         dsp_rw_q <= hold_q.wdata[7:3];
         coeff_q  <= hold_q.wdata[CDR_DSPCTL_COEFF];
      end
   end

   assign left_force_float           = pgm_q[CDR_PGM_LEFT_FLOAT];
   assign right_force_float          = pgm_q[CDR_PGM_RIGHT_FLOAT];
   assign program_select             = pgm_q[CDR_PGM_SEL_MSB:0];
   assign builtin_coefficient_select = coeff_q;
   // in bridged mono both halves drive one load, so a one-sided forced float is suppressed
   assign left_output_float  = (left_force_float & ~parallel_bridged_mono)
                               | left_ctrl_float;
   assign right_output_float = (right_force_float & ~parallel_bridged_mono)
                               | right_ctrl_float;

   // ==========================================================
   // read answer and acknowledge; unmapped addresses read zero
   wire [7:0] rd_det = {det_rsvd_q, flag_q};
   wire [7:0] rd_dsp = {dsp_rw_q, 2'b00, coeff_q};
   wire [7:0] rd_mux = hit_det ? rd_det :
                       hit_pgm ? pgm_q  :
                       hit_dsp ? rd_dsp : 8'h00;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         req_seen_q   <= 1'b0;
         ack_tog_q    <= 1'b0;
         core_rdata_q <= 8'h00;
      end else begin
         req_seen_q <= req_s;
         if (core_go) begin
            ack_tog_q    <= ~ack_tog_q;
            core_rdata_q <= rd_mux;
         end
      end
   end

   // ==========================================================
   // checks; flags are registered, so flag checks look one core cycle on
   a_auto_rate_flag: assert property (@(posedge clock) disable iff (!rst_n)
      det.auto_mode && !det.rate_valid |=> flag_q[0])
      else $error("auto mode invalid rate not flagged");
   a_rate_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
      det.auto_mode && det.rate_valid |=> !flag_q[0])
      else $error("auto mode valid rate flagged");
   a_fixed_rate_flag: assert property (@(posedge clock) disable iff (!rst_n)
      !det.auto_mode && det.rate_mismatch |=> flag_q[0])
      else $error("fixed rate mismatch not flagged");
   a_fixed_rate_clear: assert property (@(posedge clock) disable iff (!rst_n)
      !det.auto_mode && !det.rate_mismatch |=> !flag_q[0])
      else $error("fixed rate flagged without mismatch");
   a_ignore_still_flags: assert property (@(posedge clock) disable iff (!rst_n)
      det.error_ignore && !det.auto_mode && det.rate_mismatch |=> flag_q[0])
      else $error("rate error masked by ignore setting");
   a_bclk_valid_window: assert property (@(posedge clock) disable iff (!rst_n)
      flag_q[1] |-> $past(det.ratio_stable) && $past(det.bclk_ratio) >= CDR_RATIO_MIN
                    && $past(det.bclk_ratio) <= CDR_RATIO_MAX)
      else $error("bit clock flagged valid outside window");
   a_bclk_valid_set: assert property (@(posedge clock) disable iff (!rst_n)
      det.ratio_stable && det.bclk_ratio >= CDR_RATIO_MIN
      && det.bclk_ratio <= CDR_RATIO_MAX |=> flag_q[1])
      else $error("valid bit clock not flagged");
   a_bclk_unstable_invalid: assert property (@(posedge clock) disable iff (!rst_n)
      !det.ratio_stable |=> !flag_q[1])
      else $error("unstable bit clock flagged valid");
   a_miss_range_flags: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 flag_q[2] == $past(det.bclk_missing) && flag_q[4] == $past(det.pll_overrate)
      && flag_q[5] == $past(det.bclk_out_of_range))
      else $error("clock flag does not follow detector");
   a_pll_off_unlocked: assert property (@(posedge clock) disable iff (!rst_n)
      !det.pll_enable |=> !flag_q[3])
      else $error("disabled pll shown locked");
   a_force_left_float: assert property (@(posedge clock) disable iff (!rst_n)
      left_force_float && !parallel_bridged_mono |-> left_output_float)
      else $error("left force ignored");
   a_force_right_float: assert property (@(posedge clock) disable iff (!rst_n)
      right_force_float && !parallel_bridged_mono |-> right_output_float)
      else $error("right force ignored");
   a_bridged_no_force: assert property (@(posedge clock) disable iff (!rst_n)
      parallel_bridged_mono && !right_ctrl_float |-> !right_output_float)
      else $error("force acts in bridged mono");
   a_force_hold_state: assert property (@(posedge clock) disable iff (!rst_n)
      left_force_float && !wr_pgm |=> left_force_float)
      else $error("left force released without write");
   a_force_right_hold: assert property (@(posedge clock) disable iff (!rst_n)
      right_force_float && !wr_pgm |=> right_force_float)
      else $error("right force released without write");
   a_program_sel_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !wr_pgm |=> $stable(program_select))
      else $error("program select changed without write");
   a_coeff_write_take: assert property (@(posedge clock) disable iff (!rst_n)
      wr_dsp |=> builtin_coefficient_select == $past(hold_q.wdata[0]))
      else $error("coefficient select not written");
   a_coeff_sel_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !wr_dsp |=> $stable(builtin_coefficient_select))
      else $error("coefficient select changed without write");
   a_status_write_ignored: assert property (@(posedge clock) disable iff (!rst_n)
      wr_det |=> flag_q == $past(flag_d))
      else $error("status bits altered by write");

   // link handshake: one request in flight, acknowledged once and in time
   a_busy_after_take: assert property (@(posedge link_clock) disable iff (!rst_n)
      link_take |=> bus_busy)
      else $error("port not busy after a taken request");
   a_link_ack_bound: assert property (@(posedge link_clock) disable iff (!rst_n)
      link_take |=> !bus_ack ##[1:10] bus_ack)
      else $error("request not acknowledged in time");
   a_ack_single_pulse: assert property (@(posedge link_clock) disable iff (!rst_n)
      bus_ack |=> !bus_ack)
      else $error("acknowledge longer than one cycle");

   // main scenarios
   c_write_program: cover property (@(posedge clock) disable iff (!rst_n) wr_pgm);
   c_read_status: cover property (@(posedge clock) disable iff (!rst_n)
      core_go && !hold_q.write && hit_det);
   c_bridged_forced: cover property (@(posedge clock) disable iff (!rst_n)
      parallel_bridged_mono && left_force_float);
   c_release_force: cover property (@(posedge clock) disable iff (!rst_n)
      wr_pgm && left_force_float && !hold_q.wdata[CDR_PGM_LEFT_FLOAT]);
   c_bclk_valid: cover property (@(posedge clock) disable iff (!rst_n)
      flag_q[CDR_FLAG_BCLK_OK]);
endmodule
`default_nettype wire

// File: bench/cdr_host_model.sv
// host controller model driving the register bank's command port
`timescale 1ns/10ps
`default_nettype none
module cdr_host_model (
   input  wire logic              link_clock,
   input  wire logic              bus_busy,
   input  wire logic              bus_ack,
   input  wire logic [7:0]        bus_rdata,
   output var  logic              bus_req,
   output var  cdr_pkg::cdr_req_t bus_cmd
);
   import cdr_pkg::*;
   initial begin
      bus_req = 1'b0;
      bus_cmd = '0;
   end
   // ==========================================================
   // one access per call; released command lines show the inverse of the last one
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                         output logic [7:0] rd, output logic ok);
      cdr_req_t c;
      int       n;
      c = '{write: wr, addr: a, wdata: wd};
      ok = 1'b0;
      rd = 8'h00;
      @(posedge link_clock);
      bus_req <= 1'b1;
      bus_cmd <= c;
      @(posedge link_clock);
      // a busy port refuses the request silently, so hold it until taken
      for (n = 0; n < 20 && bus_busy !== 1'b0; n++) begin
         @(posedge link_clock);
      end
      bus_req <= 1'b0;
      bus_cmd <= ~c;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge link_clock);
         if (bus_ack === 1'b1) begin
            ok = 1'b1;
            rd = bus_rdata;
         end
      end
   endtask
endmodule
`default_nettype wire

// File: bench/tb_clock_detect_and_dsp_control_regs.sv
// self-checking bench for the clock-detect and dsp control register bank
`timescale 1ns/10ps
`default_nettype none
module tb_clock_detect_and_dsp_control_regs;
   import cdr_pkg::*;
   logic       clock, rst_n, link_clock, bus_req, bus_busy, bus_ack, pll_locked, bridged;
   logic       lctl, rctl, lout, rout, lfrc, rfrc, builtin, ok;
   logic [7:0] bus_rdata, rd;
   logic [1:0] psel;
   cdr_req_t   bus_cmd;
   cdr_det_t   det;
   int         mismatches, tests_run;
   logic [9:0] corner [4] = '{10'h01F, 10'h020, 10'h200, 10'h201};

   cdr_regs i_cdr_regs (.clock(clock), .rst_n(rst_n), .link_clock(link_clock),
      .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_busy(bus_busy), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata), .det(det), .pll_locked(pll_locked),
      .parallel_bridged_mono(bridged), .left_ctrl_float(lctl), .right_ctrl_float(rctl),
      .left_output_float(lout), .right_output_float(rout), .left_force_float(lfrc),
      .right_force_float(rfrc), .program_select(psel), .builtin_coefficient_select(builtin));
   cdr_host_model i_cdr_host_model (.link_clock(link_clock), .bus_busy(bus_busy),
      .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_req(bus_req), .bus_cmd(bus_cmd));

   // ==========================================================
   // clocks; the link clock is offset so its edges never meet the core's
   always #25 clock = ~clock;
   initial begin
      link_clock = 1'b0;
      #7;
      forever #40 link_clock = ~link_clock;
   end

   // ==========================================================
   // checking helpers
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // settle a couple of core cycles so applied writes show at the outputs
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      i_cdr_host_model.access(wr, a, wd, rd, ok);
      check("ack", {7'h00, ok}, 8'h01);
      repeat (2) @(posedge clock);
   endtask
   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      check(name, rd, exp);
   endtask
   function automatic logic [5:0] exp_flags(input cdr_det_t d, input logic lk);
      return {d.bclk_out_of_range, d.pll_overrate, lk & d.pll_enable, d.bclk_missing,
              d.ratio_stable & (d.bclk_ratio >= CDR_RATIO_MIN) & (d.bclk_ratio <= CDR_RATIO_MAX),
              d.auto_mode ? ~d.rate_valid : d.rate_mismatch};
   endfunction
   function automatic logic exp_f(input logic f, input logic b, input logic c);
      return (f & ~b) | c;
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      cdr_det_t   d;
      logic [7:0] w;
      logic [2:0] m;
      int         i;
      int         j;
      clock = 1'b0;
      rst_n = 1'b0;
      det = '0;
      pll_locked = 1'b0;
      bridged = 1'b0;
      lctl = 1'b0;
      rctl = 1'b0;
      mismatches = 0;
      tests_run = 0;
      void'($urandom(98));
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge link_clock);
      rchk("flags_rst", CDR_OFF_CLKDET, CDR_RST_CLKDET);
      rchk("pgm_rst", CDR_OFF_PGM, CDR_RST_PGM);
      rchk("dspctl_rst", CDR_OFF_DSPCTL, CDR_RST_DSPCTL);
      check("sel_rst", {6'h00, psel}, {6'h00, CDR_PGM_ROM1});
      check("coef_rst", {7'h00, builtin}, 8'h01);
      // status bits must ignore the write, the spare top bits keep it
      acc(1'b1, CDR_OFF_CLKDET, 8'hFF);
      for (i = 0; i < 16; i++) begin
         d = cdr_det_t'($urandom);
         if (i < 4) begin
            d.bclk_ratio = corner[i];
            d.ratio_stable = 1'b1;
         end
         @(posedge clock);
         det <= d;
         pll_locked <= 1'($urandom);
         repeat (6) @(posedge clock);
         rchk("flags", CDR_OFF_CLKDET, {2'h3, exp_flags(d, pll_locked)});
      end
      for (i = 0; i < 16; i++) begin
         w = {4'($urandom), 4'(i)};
         acc(1'b1, CDR_OFF_PGM, w);
         rchk("pgm", CDR_OFF_PGM, w);
         check("sel", {6'h00, psel}, {6'h00, w[1:0]});
         check("force", {6'h00, lfrc, rfrc}, {6'h00, w[3:2]});
         for (j = 0; j < 8; j++) begin
            m = 3'(j);
            @(posedge clock);
            {bridged, lctl, rctl} <= m;
            repeat (2) @(posedge clock);
            check("float", {6'h00, lout, rout},
                  {6'h00, exp_f(w[3], m[2], m[1]), exp_f(w[2], m[2], m[0])});
         end
      end
      // both forces are set now; other traffic must not release them
      acc(1'b1, CDR_OFF_DSPCTL, 8'hFE);
      rchk("dspctl", CDR_OFF_DSPCTL, 8'hF8);
      check("coef_host", {7'h00, builtin}, 8'h00);
      acc(1'b1, 8'h41, 8'h55);
      rchk("unmapped", 8'h41, 8'h00);
      check("hold", {6'h00, lfrc, rfrc}, 8'h03);
      acc(1'b1, CDR_OFF_PGM, 8'h01);
      check("release", {6'h00, lfrc, rfrc}, 8'h00);
      acc(1'b1, CDR_OFF_DSPCTL, 8'h01);
      check("coef_rom", {7'h00, builtin}, 8'h01);
      test_done();
   end

   // a hung handshake ends the run as a failure
   initial begin
      #2_000_000;
      mismatches++;
      test_done();
   end
endmodule
`default_nettype wire
